// ==== shared/dac_packer_cfg.svh ====
// Constants of the ping-pong word packer: widths, bit positions, reset values and cycle counts.
// Assumes inclusion by bare name from the package and the word packer module.
`ifndef DAC_PACKER_CFG_SVH
`define DAC_PACKER_CFG_SVH

`define DPK_BUS_W            32
`define DPK_SAMPLE_W         14
`define DPK_LANES            14
`define DPK_SAMPLES_PER_LOAD 8
`define DPK_LOAD_W           112
`define DPK_CH0_LSB          0
`define DPK_CH1_LSB          16
`define DPK_MEM_AW           8
`define DPK_FIFO_DEPTH       16
`define DPK_LOW_WATER        4
`define DPK_CLK_PERIOD_NS    40
`define DPK_READ_DIV         2
`define DPK_LOAD_DIV         4
`define DPK_SHIFT_PER_LOAD   4
`define DPK_PTR_RST          0

`endif

// ==== shared/dac_packer_pkg.sv ====
// Types shared by the ping-pong word packer, the converter sink model and the test bench.
// Assumes dac_packer_cfg.svh is on the include path.
`include "dac_packer_cfg.svh"

package dac_packer_pkg;

  typedef logic [`DPK_SAMPLE_W-1:0] sample_t;

  typedef logic [`DPK_LOAD_W-1:0] load_word_t;

  typedef struct packed {
    logic                   wr;
    logic [`DPK_MEM_AW:0]   addr;
    logic [`DPK_BUS_W-1:0]  data;
  } bus_write_t;

  typedef enum logic [2:0] {
    RD_GATHER0 = 3'h1,
    RD_GATHER1 = 3'h2,
    RD_PUSH    = 3'h4
  } read_state_t;

endpackage

// ==== logic/word_fifo.sv ====
// Synchronous FIFO with valid and ready on both sides.
// Assumes DEPTH is a power of two; one clock, synchronous active-high reset.
`timescale 1ns/1ns

module word_fifo #(
  parameter int WIDTH = 112,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_in,        // Block clock.
  input  wire logic             sys_rst_in,    // Synchronous reset, active high.
  input  wire logic             in_valid_in,   // Producer offers a word.
  output logic                  in_ready_out,  // Room for a word.
  input  wire logic [WIDTH-1:0] in_data_in,    // Word offered.
  output logic                  out_valid_out, // A word is waiting.
  input  wire logic             out_ready_in,  // Consumer takes the word.
  output logic [WIDTH-1:0]      out_data_out   // Oldest word.
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      wr_ptr_next;
  logic [AW:0]      rd_ptr_reg;
  logic [AW:0]      rd_ptr_next;
  logic             push;
  logic             pop;

  // Full when the pointers differ only in the wrap bit.
  assign in_ready_out  = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                           (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
  assign out_valid_out = (wr_ptr_reg != rd_ptr_reg);
  assign out_data_out  = mem[rd_ptr_reg[AW-1:0]];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_ready_in && out_valid_out;

  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    if (push) begin
      wr_ptr_next = wr_ptr_reg + (AW+1)'(1);
    end
    if (pop) begin
      rd_ptr_next = rd_ptr_reg + (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data_in;
    end
  end

endmodule

// ==== logic/dac_pingpong_word_packer.sv ====
// Packs 32-bit bus writes into 112-bit parallel load words for fourteen 8:1 serializers.
// Assumes the bus master clock is slower than clk_in and that data is stable at its falling edge.
//
// Overview of operation
// R01: Every load presents all 112 bits.
// R02: Buffer samples between producer and load timing.
// R03: Each bus word carries two 14-bit samples.
// R04: Bits 29:16 channel 1, 13:0 channel 0.
// R05: Gather eight samples before rearranging them.
// R06: Even addresses first memory, odd second.
// R07: Address bit 0 selects, rest addresses.
// R08: Write port runs on bus master clock; here it runs on clk_in, at the synchronised falling bus clock edge.
// R09: Read both memories at half rate.
// R10: Even plus odd write form one double word.
// R11: Two reads make one load, half rate.
// R12: Shift clock is four times load clock.
// R13: Request new data when samples run low.
// R14: Source must tolerate DAC stall cycles.
// R15: Serializer inputs hold one bit position.
// R16: Read only complete pairs; pointers reset zero.
`timescale 1ns/1ns
`include "dac_packer_cfg.svh"

module dac_pingpong_word_packer #(
  parameter int FIFO_DEPTH = `DPK_FIFO_DEPTH,
  parameter int LOW_WATER  = `DPK_LOW_WATER
) (
  input  wire logic                        clk_in,                  // Block clock, 25 MHz.
  input  wire logic                        sys_rst_in,              // Sync reset, active high.
  input  wire logic                        bus_clk_in,              // Bus master clock pin.
  input  wire logic                        bus_wr_in,               // Bus write request.
  input  wire logic [`DPK_MEM_AW:0]        bus_addr_in,             // Bus word address.
  input  wire logic [`DPK_BUS_W-1:0]       bus_data_in,             // Bus write data.
  output logic                             data_request_out,        // Buffered data low.
  output logic                             parallel_load_clock_out, // Load clock to serializers.
  output logic                             load_strobe_out,         // New load word this period.
  output logic                             underrun_out,            // Load slot with no data.
  output dac_packer_pkg::load_word_t       load_word_out            // Serializer parallel inputs.
);

  localparam int AW    = `DPK_MEM_AW;
  localparam int DEPTH = 1 << AW;
  localparam int SW    = `DPK_SAMPLE_W;
  localparam int NS    = `DPK_SAMPLES_PER_LOAD;
  localparam logic [1:0] LOAD_LAST = 2'(`DPK_LOAD_DIV - 1);
  // The shift clock is made outside from the load clock; it must run this many times faster.
  localparam int SHIFT_PER_LOAD = `DPK_SHIFT_PER_LOAD; // [R12]

  // Synchronisers for the bus pins.
  logic [2:0]                  bus_clk_sync_reg;
  dac_packer_pkg::bus_write_t  bus_s1_reg;
  dac_packer_pkg::bus_write_t  bus_s2_reg;
  logic                        wr_fire;
  logic [AW-1:0]               wr_idx;

  // Ping-pong memories and write bookkeeping.
  logic [`DPK_BUS_W-1:0]       mem_even [DEPTH];
  logic [`DPK_BUS_W-1:0]       mem_odd  [DEPTH];
  logic [AW:0]                 wr_ptr_reg;
  logic [AW:0]                 wr_ptr_next;
  logic                        even_pending_reg;
  logic                        even_pending_next;
  logic                        req_reg;
  logic                        req_next;
  logic [AW:0]                 level;

  // Read engine.
  dac_packer_pkg::read_state_t state_reg;
  dac_packer_pkg::read_state_t state_next;
  logic                        rd_phase_reg;
  logic                        rd_phase_next;
  logic [AW:0]                 rd_ptr_reg;
  logic [AW:0]                 rd_ptr_next;
  logic [NS-1:0][SW-1:0]       gather_reg;
  logic [NS-1:0][SW-1:0]       gather_next;
  logic [`DPK_BUS_W-1:0]       rd_even;
  logic [`DPK_BUS_W-1:0]       rd_odd;
  logic                        rd_fire;
  dac_packer_pkg::load_word_t  arranged;

  // Output buffer and load side.
  logic                        fifo_in_valid;
  logic                        fifo_in_ready;
  logic                        fifo_out_valid;
  logic                        fifo_out_ready;
  dac_packer_pkg::load_word_t  fifo_out_data;
  logic [1:0]                  load_cnt_reg;
  logic [1:0]                  load_cnt_next;
  dac_packer_pkg::load_word_t  load_word_reg;
  dac_packer_pkg::load_word_t  load_word_next;
  logic                        load_strobe_reg;
  logic                        load_strobe_next;
  logic                        underrun_reg;
  logic                        underrun_next;
  logic                        pclk_reg;
  logic                        pclk_next;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      bus_clk_sync_reg <= 3'h0;
      bus_s1_reg       <= '0;
      bus_s2_reg       <= '0;
    end else begin
      bus_clk_sync_reg <= {bus_clk_sync_reg[1:0], bus_clk_in};
      bus_s1_reg       <= '{wr: bus_wr_in, addr: bus_addr_in, data: bus_data_in};
      bus_s2_reg       <= bus_s1_reg;
    end
  end

  // Writes are taken on the falling bus clock edge, mid-cycle, where the master's data is settled.
  assign wr_fire = bus_clk_sync_reg[2] && !bus_clk_sync_reg[1] && bus_s2_reg.wr; // [R08]
  assign wr_idx  = bus_s2_reg.addr[AW:1]; // [R07]

  always_ff @(posedge clk_in) begin
    if (wr_fire && !bus_s2_reg.addr[0]) begin // [R06] [R07]
      mem_even[wr_idx] <= bus_s2_reg.data;
    end
    if (wr_fire && bus_s2_reg.addr[0]) begin // [R06]
      mem_odd[wr_idx] <= bus_s2_reg.data;
    end
  end

  assign level = wr_ptr_reg - rd_ptr_reg;

  always_comb begin
    wr_ptr_next       = wr_ptr_reg;
    even_pending_next = even_pending_reg;
    if (wr_fire) begin
      if (!bus_s2_reg.addr[0]) begin
        even_pending_next = 1'b1;
      end else if (even_pending_reg) begin
        // An odd write after an even one completes a double word of four samples.
        wr_ptr_next       = wr_ptr_reg + (AW+1)'(1); // [R10] [R16]
        even_pending_next = 1'b0;
      end
    end
    req_next = (level < (AW+1)'(LOW_WATER)); // [R13]
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_ptr_reg       <= (AW+1)'(`DPK_PTR_RST); // [R16]
      even_pending_reg <= 1'b0;
      req_reg          <= 1'b1;
    end else begin
      wr_ptr_reg       <= wr_ptr_next;
      even_pending_reg <= even_pending_next;
      req_reg          <= req_next;
    end
  end

  assign rd_even = mem_even[rd_ptr_reg[AW-1:0]];
  assign rd_odd  = mem_odd[rd_ptr_reg[AW-1:0]];
  // One read slot every second cycle, and only for a complete pair.
  assign rd_fire = rd_phase_reg && (level != '0) && // [R09] [R16]
                   (state_reg != dac_packer_pkg::RD_PUSH);
  assign fifo_in_valid = (state_reg == dac_packer_pkg::RD_PUSH);

  always_comb begin
    int base;
    base          = 0;
    state_next    = state_reg;
    rd_phase_next = !rd_phase_reg;
    rd_ptr_next   = rd_ptr_reg;
    gather_next   = gather_reg;
    unique case (state_reg)
      dac_packer_pkg::RD_GATHER0,
      dac_packer_pkg::RD_GATHER1: begin
        if (rd_fire) begin
          base = (state_reg == dac_packer_pkg::RD_GATHER1) ? NS / 2 : 0;
          // Both memories are read together; each word splits into two samples.
          gather_next[base + 0] = rd_even[`DPK_CH0_LSB +: SW]; // [R03] [R04] [R09]
          gather_next[base + 1] = rd_even[`DPK_CH1_LSB +: SW]; // [R04]
          gather_next[base + 2] = rd_odd[`DPK_CH0_LSB +: SW];  // [R04]
          gather_next[base + 3] = rd_odd[`DPK_CH1_LSB +: SW];  // [R04]
          rd_ptr_next = rd_ptr_reg + (AW+1)'(1);
          state_next  = (state_reg == dac_packer_pkg::RD_GATHER1) ? // [R05] [R11]
                        dac_packer_pkg::RD_PUSH : dac_packer_pkg::RD_GATHER1;
        end
      end
      dac_packer_pkg::RD_PUSH: begin
        if (fifo_in_ready) begin
          state_next = dac_packer_pkg::RD_GATHER0;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_reg    <= dac_packer_pkg::RD_GATHER0;
      rd_phase_reg <= 1'b0;
      rd_ptr_reg   <= (AW+1)'(`DPK_PTR_RST); // [R16]
      gather_reg   <= '0;
    end else begin
      state_reg    <= state_next;
      rd_phase_reg <= rd_phase_next;
      rd_ptr_reg   <= rd_ptr_next;
      gather_reg   <= gather_next;
    end
  end

  // Serializer k input j carries bit k of sample j.
  for (genvar k = 0; k < `DPK_LANES; k++) begin : g_lane
    for (genvar j = 0; j < NS; j++) begin : g_slot
      assign arranged[k*NS + j] = gather_reg[j][k]; // [R15] [R01]
    end
  end

  // The buffer decouples the read engine from load timing; when full the engine stalls in PUSH.
  word_fifo #(
    .WIDTH ($bits(dac_packer_pkg::load_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .in_valid_in   (fifo_in_valid),  // [R02]
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (arranged),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_out_ready),
    .out_data_out  (fifo_out_data)
  );

  assign fifo_out_ready = (load_cnt_reg == LOAD_LAST);

  always_comb begin
    load_cnt_next    = load_cnt_reg + 2'h1;
    load_word_next   = load_word_reg;
    load_strobe_next = 1'b0;
    underrun_next    = 1'b0;
    if (load_cnt_reg == LOAD_LAST) begin
      if (fifo_out_valid) begin
        load_word_next   = fifo_out_data; // [R01] [R11]
        load_strobe_next = 1'b1;
      end else begin
        // A stall slot: the previous word is repeated and the source must tolerate it.
        underrun_next = 1'b1; // [R14]
      end
    end
    // Load clock rises mid-period, two cycles after the word changes.
    pclk_next = load_cnt_next[1]; // [R11]
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      load_cnt_reg    <= 2'h0;
      load_word_reg   <= '0;
      load_strobe_reg <= 1'b0;
      underrun_reg    <= 1'b0;
      pclk_reg        <= 1'b0;
    end else begin
      load_cnt_reg    <= load_cnt_next;
      load_word_reg   <= load_word_next;
      load_strobe_reg <= load_strobe_next;
      underrun_reg    <= underrun_next;
      pclk_reg        <= pclk_next;
    end
  end

  assign data_request_out        = req_reg;
  assign parallel_load_clock_out = pclk_reg;
  assign load_strobe_out         = load_strobe_reg;
  assign underrun_out            = underrun_reg;
  assign load_word_out           = load_word_reg;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence load_gap_s;
    !load_strobe_reg [*3];
  endsequence

  sequence clock_after_load_s;
    !pclk_reg ##1 !pclk_reg ##1 pclk_reg ##1 pclk_reg;
  endsequence

  load_period_a: assert property (load_strobe_reg |=> load_gap_s) // [R11]
    else $error("load strobes closer than four cycles");
  load_clock_a: assert property (load_strobe_reg |-> clock_after_load_s) // [R12]
    else $error("load clock not aligned to load word");
  load_data_a: assert property (load_strobe_reg |-> load_word_reg == $past(fifo_out_data)) // [R01]
    else $error("load word differs from buffered word");
  request_level_a: assert property (req_reg == ($past(level) < (AW+1)'(LOW_WATER))) // [R13]
    else $error("data request does not follow fill level");
  pair_only_a: assert property (rd_fire |-> wr_ptr_reg != rd_ptr_reg) // [R16]
    else $error("read of an incomplete double word");
  read_rate_a: assert property (rd_fire |=> !rd_fire) // [R09]
    else $error("reads in consecutive cycles");
  even_bank_a: assert property (wr_fire && !bus_s2_reg.addr[0] |=> // [R06]
    mem_even[$past(wr_idx)] == $past(bus_s2_reg.data))
    else $error("even write missing from first memory");
  pair_count_a: assert property (wr_fire && bus_s2_reg.addr[0] && even_pending_reg |=> // [R10]
    wr_ptr_reg == $past(wr_ptr_reg) + (AW+1)'(1))
    else $error("odd write did not complete a pair");
  two_reads_a: assert property (rd_fire && state_reg == dac_packer_pkg::RD_GATHER1 |=> // [R05]
    state_reg == dac_packer_pkg::RD_PUSH)
    else $error("second read did not lead to push");
  channel_one_a: assert property (rd_fire && state_reg == dac_packer_pkg::RD_GATHER0 |=> // [R04]
    gather_reg[1] == $past(rd_even[`DPK_CH1_LSB +: SW]))
    else $error("channel 1 sample misplaced");

endmodule

// ==== verification/dac_sink_model.sv ====
// Receiving-end model of the converter: decodes each parallel load into eight samples.
// Assumes it sees the packer's load outputs, sampled on the packer's own clock.
`timescale 1ns/1ns

module dac_sink_model (
  input  wire logic                       clk_in,      // Block clock.
  input  wire logic                       sys_rst_in,  // Sync reset, active high.
  input  wire logic                       pclk_in,     // Parallel load clock.
  input  wire logic                       strobe_in,   // New load word.
  input  wire logic                       underrun_in, // Empty load slot.
  input  wire dac_packer_pkg::load_word_t word_in,     // Serializer parallel inputs.
  output dac_packer_pkg::sample_t         smp_out [8], // Last decoded samples.
  output int                              loads_out,   // Loads received.
  output int                              err_out      // Load timing faults seen.
);
  logic [2:0] phase_reg;
  logic       started_reg;

  // The converter cannot stall, so any slot off the four-cycle grid is a fault.
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      phase_reg   <= 3'h0;
      started_reg <= 1'b0;
      loads_out   <= 0;
      err_out     <= 0;
    end else if (strobe_in || underrun_in) begin
      if (started_reg && (phase_reg != 3'h4 || pclk_in !== 1'b0 || strobe_in === underrun_in)) begin
        err_out <= err_out + 1;
      end
      phase_reg   <= 3'h1;
      started_reg <= 1'b1;
      if (strobe_in) begin
        loads_out <= loads_out + 1;
        for (int j = 0; j < 8; j++) begin
          for (int k = 0; k < 14; k++) begin
            smp_out[j][k] <= word_in[k * 8 + j];
          end
        end
      end
    end else begin
      if (started_reg && pclk_in !== (phase_reg >= 3'h2)) begin
        err_out <= err_out + 1;
      end
      phase_reg <= phase_reg + 3'h1;
    end
  end
endmodule

// ==== verification/dac_pingpong_word_packer_test.sv ====
// Self-checking bench for the ping-pong word packer and its word buffer.
// Assumes the shared package, the design files and the sink model are compiled first.
`timescale 1ns/1ns

module dac_pingpong_word_packer_test;
  logic                       clk_in      = 1'b0;
  logic                       sys_rst_in  = 1'b1;
  logic                       bus_clk_in  = 1'b0;
  logic                       bus_wr_in   = 1'b0;
  logic [8:0]                 bus_addr_in = 9'h000;
  logic [31:0]                bus_data_in = 32'h0000_0000;
  logic                       req, pclk, strobe, underrun;
  dac_packer_pkg::load_word_t word;
  dac_packer_pkg::sample_t    smp_seen [8];
  int                         loads, sink_err;
  int                         fail_count  = 0;
  int                         n_checks    = 0;

  // A small pointer threshold makes the request line move with a single pair.
  dac_pingpong_word_packer #(.LOW_WATER(1)) dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .bus_clk_in(bus_clk_in),
    .bus_wr_in(bus_wr_in), .bus_addr_in(bus_addr_in), .bus_data_in(bus_data_in),
    .data_request_out(req), .parallel_load_clock_out(pclk), .load_strobe_out(strobe),
    .underrun_out(underrun), .load_word_out(word));
  dac_sink_model sink (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .pclk_in(pclk), .strobe_in(strobe),
    .underrun_in(underrun), .word_in(word), .smp_out(smp_seen), .loads_out(loads),
    .err_out(sink_err));

  initial begin
    forever #20 clk_in = ~clk_in;
  end

  task automatic check_val(input string what, input logic [111:0] exp, input logic [111:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic check_int(input string what, input int exp, input int got);
    n_checks++;
    if (got != exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  function automatic dac_packer_pkg::sample_t smp(input int n);
    return 14'h1A53 ^ 14'(n * 16'h0259);
  endfunction

  // One bus clock period of 320 ns; pins stay put four block cycles on each side of the fall.
  task automatic bus_write(input logic [8:0] addr, input logic [31:0] data);
    bus_clk_in  <= 1'b1;
    bus_wr_in   <= 1'b1;
    bus_addr_in <= addr;
    bus_data_in <= data;
    repeat (4) @(posedge clk_in);
    bus_clk_in <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask

  task automatic t_load(input int l);
    int                         m;
    int                         k;
    dac_packer_pkg::sample_t    s;
    dac_packer_pkg::load_word_t exp_w;
    @(posedge clk_in);
    for (int w = 0; w < 4; w++) begin
      m = 4 * l + w;
      bus_write(9'(m), {2'b10, smp(2 * m + 1), 2'b01, smp(2 * m)});
      if (w == 1) begin
        k = 0;
        while (req !== 1'b0 && k < 16) begin
          @(negedge clk_in);
          k++;
        end
        check_val("request with one pair", 0, req);
        @(posedge clk_in);
      end
      if (w == 2) check_int("loads before second pair", l, loads);
    end
    bus_wr_in   <= 1'b0;
    bus_data_in <= ~bus_data_in;
    bus_addr_in <= ~bus_addr_in;
    k = 0;
    while (loads != l + 1 && k < 200) begin
      @(negedge clk_in);
      k++;
    end
    check_int("loads", l + 1, loads);
    for (int j = 0; j < 8; j++) begin
      s = smp(8 * l + j);
      check_val("sample", s, smp_seen[j]);
      for (int b = 0; b < 14; b++) exp_w[b * 8 + j] = s[b];
    end
    check_val("request after load", 1, req);
    k = 0;
    while (underrun !== 1'b1 && k < 8) begin
      @(negedge clk_in);
      k++;
    end
    check_val("empty slot flag", 1, underrun);
    check_val("held load word", exp_w, word);
    check_int("no extra load", l + 1, loads);
    $display("test load %0d done", l);
  endtask

  // Two loads written back to back; each is judged once the sink model has decoded it.
  task automatic t_burst(input int l);
    int m;
    int k;
    fork
      begin
        @(posedge clk_in);
        for (int w = 0; w < 8; w++) begin
          m = 4 * l + w;
          bus_write(9'(m), {2'b10, smp(2 * m + 1), 2'b01, smp(2 * m)});
        end
        bus_wr_in   <= 1'b0;
        bus_data_in <= ~bus_data_in;
        bus_addr_in <= ~bus_addr_in;
      end
      begin
        for (int i = 0; i < 2; i++) begin
          k = 0;
          while (loads != l + i + 1 && k < 200) begin
            @(negedge clk_in);
            k++;
          end
          check_int("burst loads", l + i + 1, loads);
          for (int j = 0; j < 8; j++) begin
            check_val("burst sample", smp(8 * (l + i) + j), smp_seen[j]);
          end
        end
      end
    join
    k = 0;
    while (underrun !== 1'b1 && k < 8) begin
      @(negedge clk_in);
      k++;
    end
    check_val("burst empty slot", 1, underrun);
    check_int("burst no extra load", l + 2, loads);
    $display("test burst done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    check_val("request in reset", 1, req);
    check_val("load flags in reset", 0, {pclk, strobe, underrun});
    check_val("load word in reset", 0, word);
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    $display("test reset done");
    repeat (4) @(posedge clk_in);
    t_load(0);
    t_load(1);
    t_load(2);
    t_burst(3);
    check_int("sink timing faults", 0, sink_err);
    finish_test();
  end

  initial begin
    #800_000;
    fail_count++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    finish_test();
  end
endmodule
